// *** rtl/tim_irq_top.sv ***
//----------------------------------------------------------------------
// tim_irq_top
//----------------------------------------------------------------------
// Purpose: interrupt mode and mask register with its status sources
// Assumes: register strobes come from the serial bus front end,
//          comparisons and strobes are synchronous to clk_in
// Notes:   bits 2:0 of the register live elsewhere and read as zero
//
// Functional notes
// R1: repeating mode interrupts above shutdown limit
// R2: status read clears; next conversion re-raises
// R3: repeating continues until below hysteresis
// R4: one-time mode gives one shutdown interrupt
// R5: one-time re-arms only after below hysteresis
// R6: one-time read clears; bit may stay clear
// R7: hot limit repeating mode when bit 6 zero
// R8: hot limit one-time mode when bit 6 set
// R9: bits 5,4,3 mask status; RW, reset zero
// R10: shutdown status set above either shutdown limit
// R11: interrupt asserted while unmasked status bit set
`timescale 1ns/10ps
module tim_irq_top
   import tim_pkg::*;
(
   input  wire logic        clk_in,          // 10 MHz system clock
   input  wire logic        sys_rst_in,      // async reset, active high
   input  wire logic        reg_wr_in,       // register write strobe
   input  wire logic        reg_rd_in,       // register read strobe
   input  wire logic [7:0]  reg_addr_in,     // register offset
   input  wire logic [7:0]  reg_wdata_in,    // write data
   input  wire logic        status_rd_in,    // status register read
   input  wire logic        conv_done_in,    // conversion complete pulse
   input  wire tim_cmp_type shut_hi_in,      // high shutdown limit cmp
   input  wire tim_cmp_type shut_lo_in,      // low shutdown limit cmp
   input  wire tim_cmp_type hot_in,          // hot limit cmp
   input  wire logic        intrusion_input_in, // intrusion latched
   input  wire logic        fan2_speed_input_in, // fan 2 limit hit
   input  wire logic        hot_mask_in,     // hot mask, other register
   output logic [7:0]       reg_rdata_out,   // register read data
   output logic [7:0]       status_out,      // status bits owned here
   output logic             irq_n_out        // interrupt, active low
);

   logic [7:TIM_RW_LSB] mode_mask;
   tim_cmp_type         shut_cmp;
   logic                shut_flag;
   logic                hot_flag;
   logic                shut_armed;
   logic                hot_armed;
   logic                intr_flag;
   logic                fan2_flag;
   logic [7:0]          next_status;
   logic [7:0]          eff_mask;
   logic                next_irq_n;

   //---------------------------------------------------------------
   // mask and mode register
   //---------------------------------------------------------------
   // all five bits read/write, zero after reset
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         mode_mask <= TIM_MASK2_RESET[7:TIM_RW_LSB];     // see R9
      else if (reg_wr_in && reg_addr_in == TIM_MASK2_ADDR)
         mode_mask <= reg_wdata_in[7:TIM_RW_LSB];        // see R9
   end

   // readback, other offsets answer zero
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         reg_rdata_out <= 8'h00;
      else if (reg_rd_in)
         reg_rdata_out <= (reg_addr_in == TIM_MASK2_ADDR)
                          ? {mode_mask, 3'h0} : 8'h00;
   end

   //---------------------------------------------------------------
   // limit excursions
   //---------------------------------------------------------------
   // either shutdown limit counts; hysteresis needs both sides inside
   assign shut_cmp.over       = shut_hi_in.over || shut_lo_in.over; // see R10
   assign shut_cmp.below_hyst = shut_hi_in.below_hyst
                                && shut_lo_in.below_hyst;

   tim_excursion u_shut
   (
      .clk_in       (clk_in),
      .sys_rst_in   (sys_rst_in),
      .conv_done_in (conv_done_in),
      .cmp_in       (shut_cmp),
      .one_time_in  (mode_mask[TIM_SHUT_MODE_BIT]),     // see R1 R4
      .clear_in     (status_rd_in),
      .flag_out     (shut_flag),
      .armed_out    (shut_armed)
   );

   tim_excursion u_hot
   (
      .clk_in       (clk_in),
      .sys_rst_in   (sys_rst_in),
      .conv_done_in (conv_done_in),
      .cmp_in       (hot_in),
      .one_time_in  (mode_mask[TIM_HOT_MODE_BIT]),      // see R7 R8
      .clear_in     (status_rd_in),
      .flag_out     (hot_flag),
      .armed_out    (hot_armed)
   );

   //---------------------------------------------------------------
   // level-set status bits, read clears, set wins
   //---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         intr_flag <= 1'b0;
      else if (intrusion_input_in)
         intr_flag <= 1'b1;
      else if (status_rd_in)
         intr_flag <= 1'b0;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         fan2_flag <= 1'b0;
      else if (fan2_speed_input_in)
         fan2_flag <= 1'b1;
      else if (status_rd_in)
         fan2_flag <= 1'b0;
   end

   //---------------------------------------------------------------
   // status image and interrupt
   //---------------------------------------------------------------
   always_comb
   begin
      next_status = TIM_STAT_RESET;
      next_status[TIM_STAT_SHUT_BIT] = shut_flag;
      next_status[TIM_STAT_INTR_BIT] = intr_flag;
      next_status[TIM_STAT_FAN2_BIT] = fan2_flag;
      next_status[TIM_STAT_HOT_BIT]  = hot_flag;
      eff_mask = 8'h00;
      eff_mask[TIM_STAT_SHUT_BIT] = mode_mask[TIM_SHUT_MASK_BIT]; // see R9
      eff_mask[TIM_STAT_INTR_BIT] = mode_mask[TIM_INTR_MASK_BIT]; // see R9
      eff_mask[TIM_STAT_FAN2_BIT] = mode_mask[TIM_FAN2_MASK_BIT]; // see R9
      eff_mask[TIM_STAT_HOT_BIT]  = hot_mask_in;
      next_irq_n = ~|(next_status & ~eff_mask);          // see R11
   end

   // registered so the pin never glitches on mask writes
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         status_out <= TIM_STAT_RESET;
         irq_n_out  <= 1'b1;
      end
      else
      begin
         status_out <= next_status;
         irq_n_out  <= next_irq_n;                        // see R11
      end
   end

   //---------------------------------------------------------------
   // checks
   //---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence shut_rep_hit;
      conv_done_in && !mode_mask[TIM_SHUT_MODE_BIT] && shut_cmp.over;
   endsequence

   sequence shut_one_blocked;
      conv_done_in && mode_mask[TIM_SHUT_MODE_BIT] && !shut_armed
      && !shut_cmp.below_hyst && !status_out[TIM_STAT_SHUT_BIT]
      && !shut_flag;
   endsequence

   AST_SHUT_REPEAT: assert property // see R1
      (shut_rep_hit |=> ##1 status_out[TIM_STAT_SHUT_BIT])
      else $error("shutdown repeat did not set status");

   AST_READ_CLEARS: assert property // see R2
      (status_rd_in && !conv_done_in && !intrusion_input_in
       |=> ##1 !status_out[TIM_STAT_SHUT_BIT]
       && !status_out[TIM_STAT_INTR_BIT])
      else $error("status read did not clear");

   AST_REPEAT_REARM: assert property // see R3
      (conv_done_in && !mode_mask[TIM_SHUT_MODE_BIT]
       && shut_cmp.below_hyst && !shut_flag
       |=> ##1 !status_out[TIM_STAT_SHUT_BIT])
      else $error("status set below hysteresis");

   AST_ONE_SHOT: assert property // see R4
      (conv_done_in && mode_mask[TIM_SHUT_MODE_BIT] && shut_armed
       && shut_cmp.over && !shut_cmp.below_hyst
       |=> !shut_armed ##1 status_out[TIM_STAT_SHUT_BIT])
      else $error("one-time shutdown interrupt missing");

   AST_ONE_BLOCKED: assert property // see R5 R6
      (shut_one_blocked |=> ##1 !status_out[TIM_STAT_SHUT_BIT])
      else $error("one-time mode raised a second interrupt");

   AST_HOT_REPEAT: assert property // see R7
      (conv_done_in && !mode_mask[TIM_HOT_MODE_BIT] && hot_in.over
       && !hot_in.below_hyst |=> ##1 status_out[TIM_STAT_HOT_BIT])
      else $error("hot repeat did not set status");

   AST_HOT_ONE_TIME: assert property // see R8
      (conv_done_in && mode_mask[TIM_HOT_MODE_BIT] && !hot_armed
       && !hot_in.below_hyst |=> !hot_armed)
      else $error("hot one-time re-armed without hysteresis");

   AST_MASK_WRITE: assert property // see R9
      (reg_wr_in && reg_addr_in == TIM_MASK2_ADDR && !reg_rd_in ##1
       reg_rd_in && reg_addr_in == TIM_MASK2_ADDR && !reg_wr_in
       |=> reg_rdata_out == {$past(reg_wdata_in, 2)
                             & 8'hf8})
      else $error("mask register readback wrong");

   AST_MASKED_QUIET: assert property // see R9 R11
      (next_status == 8'h20 && mode_mask[TIM_SHUT_MASK_BIT]
       |=> irq_n_out)
      else $error("masked shutdown bit drove interrupt");

   AST_IRQ_FOLLOWS: assert property // see R11
      (|(status_out & ~eff_mask) && $stable(eff_mask)
       |-> !irq_n_out)
      else $error("interrupt not asserted for unmasked status");

   AST_SHUT_EITHER: assert property // see R10
      (conv_done_in && !mode_mask[TIM_SHUT_MODE_BIT]
       && shut_lo_in.over && !shut_cmp.below_hyst
       |=> shut_flag)
      else $error("low shutdown limit did not set status");

endmodule : tim_irq_top

// *** rtl/tim_pkg.sv ***
//----------------------------------------------------------------------
// tim_pkg
//----------------------------------------------------------------------
// Purpose: constants and types for the temperature interrupt mode/mask
// Assumes: 8-bit register port from the serial front end
// Notes:   status bit positions match the monitor's status register
package tim_pkg;

   // register map
   localparam logic [7:0] TIM_MASK2_ADDR  = 8'h04;
   localparam logic [7:0] TIM_MASK2_RESET = 8'h00;

   // mode and mask field positions in the mask/mode register
   localparam int TIM_SHUT_MODE_BIT = 7;
   localparam int TIM_HOT_MODE_BIT  = 6;
   localparam int TIM_SHUT_MASK_BIT = 5;
   localparam int TIM_INTR_MASK_BIT = 4;
   localparam int TIM_FAN2_MASK_BIT = 3;
   localparam int TIM_RW_LSB        = 3;

   // status bit positions
   localparam int TIM_STAT_SHUT_BIT = 5;
   localparam int TIM_STAT_INTR_BIT = 4;
   localparam int TIM_STAT_FAN2_BIT = 3;
   localparam int TIM_STAT_HOT_BIT  = 0;
   localparam logic [7:0] TIM_STAT_RESET = 8'h00;

   // one limit comparison result, valid with the conversion strobe
   typedef struct packed
   {
      logic over;        // temperature above the limit
      logic below_hyst;  // temperature below the hysteresis limit
   } tim_cmp_type;

endpackage : tim_pkg

// *** rtl/tim_excursion.sv ***
//----------------------------------------------------------------------
// tim_excursion
//----------------------------------------------------------------------
// Purpose: one limit's status flag in repeating or one-time mode
// Assumes: cmp_in is valid while conv_done_in pulses
// Notes:   a set on the same edge as a clear wins
`timescale 1ns/10ps
module tim_excursion
   import tim_pkg::*;
(
   input  wire logic        clk_in,       // system clock
   input  wire logic        sys_rst_in,   // async reset, active high
   input  wire logic        conv_done_in, // conversion complete pulse
   input  wire tim_cmp_type cmp_in,       // limit comparison
   input  wire logic        one_time_in,  // 1 = one-time mode
   input  wire logic        clear_in,     // status read pulse
   output logic             flag_out,     // status flag
   output logic             armed_out     // one-time mode armed
);

   logic in_exc;
   logic set_rep;
   logic set_one;

   //---------------------------------------------------------------
   // excursion tracking
   //---------------------------------------------------------------
   // excursion lasts from crossing the limit until below hysteresis
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         in_exc <= 1'b0;
      else if (conv_done_in && cmp_in.below_hyst)
         in_exc <= 1'b0;                                 // see R3
      else if (conv_done_in && cmp_in.over)
         in_exc <= 1'b1;
   end

   // repeating: every conversion inside an excursion sets the flag
   assign set_rep = conv_done_in && !one_time_in && !cmp_in.below_hyst
                    && (cmp_in.over || in_exc);           // see R2 R3 R7
   // one-time: only the first crossing while armed
   assign set_one = conv_done_in && one_time_in && armed_out
                    && cmp_in.over;                       // see R4 R8

   //---------------------------------------------------------------
   // re-arm tracking, kept internal and invisible to software
   //---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         armed_out <= 1'b1;
      else if (conv_done_in && cmp_in.below_hyst)
         armed_out <= 1'b1;                              // see R5
      else if (set_one)
         armed_out <= 1'b0;                              // see R5 R8
   end

   //---------------------------------------------------------------
   // status flag, read clears, set wins
   //---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         flag_out <= 1'b0;
      else if (set_rep || set_one)
         flag_out <= 1'b1;
      else if (clear_in)
         flag_out <= 1'b0;                               // see R6
   end

endmodule : tim_excursion

// *** dv/tim_host_model.sv ***
//----------------------------------------------------------------------
// tim_host_model
//----------------------------------------------------------------------
// Purpose: host side of the register and status strobes
// Assumes: strobes are taken on the rising edge of clk_in
// Notes:   address and data are scrambled between requests
`timescale 1ns/10ps
module tim_host_model
(
   input  wire logic       clk_in,      // system clock
   output logic            wr_out,      // write strobe
   output logic            rd_out,      // read strobe
   output logic [7:0]      addr_out,    // register offset
   output logic [7:0]      wdata_out,   // write data
   output logic            stat_rd_out  // status read strobe
);
   //---------------------------------------------------------------
   // request driver
   //---------------------------------------------------------------
   // idle bus shows a pattern, so stale data is never seen as valid
   initial
   begin
      {wr_out, rd_out, stat_rd_out} = 3'h0;
      {addr_out, wdata_out} = 16'ha55a;
   end

   // one request, held through the taking edge, then released; one idle
   // edge follows so the next request never lands in the same time step
   task automatic xfer(input logic w, r, s, input logic [7:0] a, d);
   begin
      {wr_out, rd_out, stat_rd_out, addr_out, wdata_out} = {w, r, s, a, d};
      @(posedge clk_in);
      #10;
      {wr_out, rd_out, stat_rd_out} = 3'h0;
      addr_out  = ~a;
      wdata_out = ~d;
      @(posedge clk_in);
      #10;
   end
   endtask : xfer

   // write then read back on the very next edge, no idle cycle between
   task automatic wr_rd(input logic [7:0] a, d);
   begin
      {wr_out, addr_out, wdata_out} = {1'b1, a, d};
      @(posedge clk_in);
      #10;
      {wr_out, rd_out} = 2'b01;
      wdata_out = ~d;
      @(posedge clk_in);
      #10;
      rd_out   = 1'b0;
      addr_out = ~a;
      @(posedge clk_in);
      #10;
   end
   endtask : wr_rd
endmodule : tim_host_model

// *** dv/tb.sv ***
//----------------------------------------------------------------------
// tb
//----------------------------------------------------------------------
// Purpose: self-checking bench for the interrupt mode and mask block
// Assumes: status and interrupt settle two edges after their cause
// Notes:   comparison inputs are zero until the first conversion, then random whenever no conversion is due
`timescale 1ns/10ps
module tb
   import tim_pkg::*;
;
   logic        clk_in, sys_rst_in, wr, rd, stat_rd, conv_done;
   logic        intrusion, fan2, hot_mask, irq_n;
   logic [7:0]  addr, wdata, rdata, status, d;
   tim_cmp_type shut_hi, shut_lo, hot;
   int          seed, miscompares, samples_checked, p;

   tim_host_model u_host (.clk_in(clk_in), .wr_out(wr), .rd_out(rd),
      .addr_out(addr), .wdata_out(wdata), .stat_rd_out(stat_rd));
   tim_irq_top u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .status_rd_in(stat_rd),
      .conv_done_in(conv_done), .shut_hi_in(shut_hi),
      .shut_lo_in(shut_lo), .hot_in(hot), .intrusion_input_in(intrusion),
      .fan2_speed_input_in(fan2), .hot_mask_in(hot_mask),
      .reg_rdata_out(rdata), .status_out(status), .irq_n_out(irq_n));

   //---------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------
   initial clk_in = 1'b0;
   always #50 clk_in = ~clk_in;

   task automatic cyc(input int n);
      repeat (n) begin @(posedge clk_in); #10; end
   endtask : cyc

   task automatic chk8(input logic [7:0] got, exp);
   begin
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t byte %h expected %h", $time, got, exp);
      end
   end
   endtask : chk8

   task automatic chk1(input logic got, exp);
   begin
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t irq %b expected %b", $time, got, exp);
      end
   end
   endtask : chk1

   function automatic logic [7:0] sbit(input int b, input logic on);
      return on ? (8'h01 << b) : 8'h00;
   endfunction : sbit

   task automatic chk_s(input int b, input logic on);
   begin
      chk8(status, sbit(b, on));
      chk1(irq_n, ~on);
   end
   endtask : chk_s

   task automatic wr_reg(input logic [7:0] a, v);
   begin
      u_host.xfer(1'b1, 1'b0, 1'b0, a, v);
   end
   endtask : wr_reg

   // read data is valid right after the edge that takes the strobe
   task automatic rd_reg(input logic [7:0] a, exp);
   begin
      u_host.xfer(1'b0, 1'b1, 1'b0, a, 8'h00);
      cyc(1);
      chk8(rdata, exp);
   end
   endtask : rd_reg

   task automatic srd();
   begin
      u_host.xfer(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
      cyc(2);
   end
   endtask : srd

   // hysteresis needs both shutdown limits below, so mirror it
   task automatic conv(input int b, input tim_cmp_type c, input logic lo);
      tim_cmp_type n;
   begin
      n = {1'b0, c.below_hyst};
      shut_hi = (b != TIM_STAT_SHUT_BIT) ? 2'b00 : (lo ? n : c);
      shut_lo = (b != TIM_STAT_SHUT_BIT) ? 2'b00 : (lo ? c : n);
      hot = (b == TIM_STAT_HOT_BIT) ? c : 2'b00;
      conv_done = 1'b1;
      cyc(1);
      conv_done = 1'b0;
      {shut_hi, shut_lo, hot} = 6'($random(seed));
      cyc(2);
   end
   endtask : conv

   task automatic print_verdict();
   begin
      if (miscompares == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask : print_verdict

   //---------------------------------------------------------------
   // main sequence
   //---------------------------------------------------------------
   initial
   begin
      seed = 32'h1481;
      {sys_rst_in, conv_done, intrusion, fan2, hot_mask} = 5'h10;
      {shut_hi, shut_lo, hot} = 6'h00;
      repeat (4) @(posedge clk_in);
      #10 sys_rst_in = 1'b0;
      chk8(rdata, 8'h00);
      chk_s(0, 1'b0);
      rd_reg(TIM_MASK2_ADDR, TIM_MASK2_RESET);
      // random bytes: bits 2:0 are not held here
      repeat (8)
      begin
         d = 8'($random(seed));
         u_host.wr_rd(TIM_MASK2_ADDR, d);
         chk8(rdata, d & 8'hf8);
      end
      wr_reg(8'h06, 8'hff);
      rd_reg(TIM_MASK2_ADDR, d & 8'hf8);
      rd_reg(8'h05, 8'h00);
      // shutdown then hot, each in repeating then one-time mode
      for (int k = 0; k < 4; k++)
      begin
         p = (k < 2) ? TIM_STAT_SHUT_BIT : TIM_STAT_HOT_BIT;
         wr_reg(TIM_MASK2_ADDR, k[0] ? sbit((k < 2) ? 7 : 6, 1'b1) : 8'h00);
         conv(p, 2'b10, 1'b0);
         chk_s(p, 1'b1);
         srd();
         chk_s(p, 1'b0);
         conv(p, 2'b00, 1'b0);
         chk_s(p, ~k[0]);
         srd();
         conv(p, 2'b01, 1'b0);
         chk_s(p, 1'b0);
         conv(p, 2'b10, 1'b1);
         chk_s(p, 1'b1);
         conv(p, 2'b01, 1'b0);
         srd();
         chk_s(p, 1'b0);
      end
      wr_reg(TIM_MASK2_ADDR, 8'h00);
      // each mask bit hides its own status bit only from the output
      for (int i = 3; i <= 5; i++)
      begin
         intrusion = (i == TIM_STAT_INTR_BIT);
         fan2 = (i == TIM_STAT_FAN2_BIT);
         cyc(1);
         {intrusion, fan2} = 2'b00;
         if (i == TIM_STAT_SHUT_BIT) conv(i, 2'b10, 1'b0);
         else cyc(2);
         chk_s(i, 1'b1);
         wr_reg(TIM_MASK2_ADDR, sbit(i, 1'b1));
         cyc(2);
         chk8(status, sbit(i, 1'b1));
         chk1(irq_n, 1'b1);
         wr_reg(TIM_MASK2_ADDR, 8'h00);
         cyc(2);
         chk1(irq_n, 1'b0);
         if (i == TIM_STAT_SHUT_BIT) conv(i, 2'b01, 1'b0);
         srd();
         chk_s(i, 1'b0);
      end
      // hot mask comes from another register but still gates the pin
      hot_mask = 1'b1;
      conv(TIM_STAT_HOT_BIT, 2'b10, 1'b0);
      chk8(status, sbit(TIM_STAT_HOT_BIT, 1'b1));
      chk1(irq_n, 1'b1);
      hot_mask = 1'b0;
      cyc(2);
      chk1(irq_n, 1'b0);
      conv(TIM_STAT_HOT_BIT, 2'b01, 1'b0);
      srd();
      chk_s(TIM_STAT_HOT_BIT, 1'b0);
      print_verdict();
   end

   // hang guard
   initial
   begin
      #5000000;
      miscompares++;
      print_verdict();
   end
endmodule : tb
